// [isr_status_top.sv]
// file: status reporting structure with event groups, status byte and service request
`timescale 1ns/100ps
// Functional notes
// - abnormal group summary drives status bit 3
// - abnormal bits 0-6 are output trips
// - abnormal bits 7-14 clamps and trips; 15 zero
// - second abnormal group bits 0, 3, 4, 6-10 mapped
// - second group bits 11-14 mapped; 15 zero
// - second group summary drives status bit 0
// - normal operation group summary drives bit 7
// - operation bits 2-5 trigger and output states
// - operation bits 8-13 regulation modes
// - chassis bits 0-5 mapped; 6-8 zero
// - status bit 2 while error queue nonempty
// - status bit 4 while output queue nonempty
// - status bit 5 from enabled standard events
// - service summary is unlatched enabled OR
// - status query shows summary, changes nothing
// - request latches bit 6 and raises line
// - serial poll returns latch, clears it if summary low
// - error queue FIFO; overflow writes -350
// - rising/falling filters pass selected edges
// - event bits sticky until read clears all
// - enable registers read/write select summary
module isr_status_top
    import isr_pkg::*;
(
    // clock, reset, enable
    input wire logic I_MCLK,
    input wire logic I_SYS_RST,
    input wire logic i_CE,
    // live conditions, one vector per group
    input wire logic [15:0] i_QUES_COND,
    input wire logic [15:0] i_QUES2_COND,
    input wire logic [15:0] i_OPER_COND,
    input wire logic [8:0] i_FRAME_COND,
    // standard event bits and output queue state
    input wire logic [7:0] i_STD_EVENT,
    input wire logic i_OUTQ_NONEMPTY,
    // error producer
    input wire logic i_ERR_PUSH,
    input wire logic [15:0] i_ERR_CODE,
    // register access port
    input wire logic i_REG_WR,
    input wire logic i_REG_RD,
    input wire logic [1:0] i_REG_GRP,
    input wire logic [3:0] i_REG_SEL,
    input wire logic [15:0] i_REG_WDATA,
    output logic [15:0] o_REG_RDATA,
    output logic o_REG_VALID,
    // serial poll and service request line
    input wire logic i_SPOLL,
    output logic o_SRQ,
    output logic [7:0] o_STB
);
    import isr_pkg::*;

    logic [15:0] cond [ISR_GROUPS];        // masked live conditions
    logic [15:0] gmask [ISR_GROUPS];       // implemented bits of each group
    logic [15:0] prev_q [ISR_GROUPS];      // last sampled condition
    logic [15:0] event_q [ISR_GROUPS];     // sticky events
    logic [15:0] enable_q [ISR_GROUPS];    // summary enables
    logic [15:0] rise_q [ISR_GROUPS];      // rising edge filter
    logic [15:0] fall_q [ISR_GROUPS];      // falling edge filter
    logic [ISR_GROUPS-1:0] gsum;           // group summaries
    logic [7:0] sre_q;                     // service request enable
    logic [7:0] ese_q;                     // standard event enable
    logic rqs_q;                           // latched service request
    logic service_summary;                             // live service summary
    logic [7:0] stb;                       // status byte without bit 6
    logic [ISR_ERRQ_AW-1:0] wr_ptr_q;      // queue write pointer
    logic [ISR_ERRQ_AW-1:0] rd_ptr_q;      // queue read pointer
    logic [ISR_ERRQ_AW:0] count_q;         // queue occupancy
    logic err_pop;                         // error read accepted
    logic push_adv;                        // push that takes a fresh slot
    logic mem_we;                          // memory write strobe
    logic [ISR_ERRQ_AW-1:0] mem_waddr;     // memory write address
    logic [15:0] mem_wdata;                // memory write data
    logic [15:0] mem_rdata;                // memory read data
    isr_errq_state_t err_state_q;          // queue read sequencing
    logic err_empty_q;                     // queue was empty at pop
    logic [15:0] rd_data_d;                // read mux
    logic sel_grp_reg;                     // access hits a group register

    // unused bit positions are forced low so they read zero, except in the rising filter until it is written after reset
    assign gmask[0] = ISR_MASK_QUES;
    assign gmask[1] = ISR_MASK_QUES2;
    assign gmask[2] = ISR_MASK_OPER;
    assign gmask[3] = ISR_MASK_FRAME;
    assign cond[0] = i_QUES_COND & gmask[0];
    assign cond[1] = i_QUES2_COND & gmask[1];
    assign cond[2] = i_OPER_COND & gmask[2];
    assign cond[3] = {7'h00, i_FRAME_COND} & gmask[3];

    assign sel_grp_reg = (i_REG_SEL <= ISR_SEL_QUES_FALL);

    // per-group condition history, filters, sticky events and enables
    for (genvar g = 0; g < ISR_GROUPS; g++)
    begin : g_grp
        logic [15:0] edges; // edges that pass the filters
        logic rd_event;     // this group's event register is read
        assign edges = (cond[g] & ~prev_q[g] & rise_q[g])
                     | (~cond[g] & prev_q[g] & fall_q[g]);
        assign rd_event = i_REG_RD && (i_REG_GRP == 2'(g)) && (i_REG_SEL == ISR_SEL_QUES_EVENT);

        // history register for edge detection
        always_ff @(posedge I_MCLK)
        begin
            if (I_SYS_RST)
                prev_q[g] <= ISR_RST_REG16;
            else if (i_CE)
                prev_q[g] <= cond[g];
        end

        // read clears, but a new edge in the same cycle still sets
        always_ff @(posedge I_MCLK)
        begin
            if (I_SYS_RST)
                event_q[g] <= ISR_RST_REG16;
            else if (i_CE)
                event_q[g] <= ((rd_event ? 16'h0000 : event_q[g]) | edges) & gmask[g];
        end

        // writable enable and filter registers
        always_ff @(posedge I_MCLK)
        begin
            if (I_SYS_RST)
            begin
                enable_q[g] <= ISR_RST_REG16;
                rise_q[g] <= ISR_RST_RISE;
                fall_q[g] <= ISR_RST_REG16;
            end
            else if (i_CE && i_REG_WR && (i_REG_GRP == 2'(g)))
            begin
                if (i_REG_SEL == ISR_SEL_QUES_ENABLE)
                    enable_q[g] <= i_REG_WDATA & gmask[g];
                if (i_REG_SEL == ISR_SEL_QUES_RISE)
                    rise_q[g] <= i_REG_WDATA & gmask[g];
                if (i_REG_SEL == ISR_SEL_QUES_FALL)
                    fall_q[g] <= i_REG_WDATA & gmask[g];
            end
        end

        // combinational summary, same cycle as the event bits
        assign gsum[g] = |(event_q[g] & enable_q[g]);
    end

    // status byte assembly; chassis summary has no documented bit and is folded
    // into the abnormal summary so that chassis alarms still reach the host
    always_comb
    begin
        stb = 8'h00;
        stb[ISR_STB_QUES2] = gsum[1];
        stb[ISR_STB_ERRQ] = (count_q != '0);
        stb[ISR_STB_QUES] = gsum[0] | gsum[3];
        stb[ISR_STB_MAV] = i_OUTQ_NONEMPTY;
        stb[ISR_STB_ESB] = |(i_STD_EVENT & ese_q);
        stb[ISR_STB_OPER] = gsum[2];
    end

    // bit 6 of the enable is ignored: the summary never feeds itself
    assign service_summary = |(stb & sre_q & 8'hBF);

    // enable registers of the status byte and the standard event summary
    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            sre_q <= ISR_RST_REG8;
            ese_q <= ISR_RST_REG8;
        end
        else if (i_CE && i_REG_WR)
        begin
            if (i_REG_SEL == ISR_SEL_SRE)
                sre_q <= i_REG_WDATA[7:0];
            if (i_REG_SEL == ISR_SEL_ESE)
                ese_q <= i_REG_WDATA[7:0];
        end
    end

    // request latch: a rising summary sets it, serial poll clears it; set wins
    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
            rqs_q <= 1'b0;
        else if (i_CE)
        begin
            if (service_summary && !rqs_q)
                rqs_q <= 1'b1;
            else if (i_SPOLL && !service_summary)
                rqs_q <= 1'b0;
        end
    end

    assign o_SRQ = rqs_q;

    // poll byte: latch in bit 6, captured before the clear takes effect
    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
            o_STB <= ISR_RST_REG8;
        else if (i_CE && i_SPOLL)
            o_STB <= stb | {1'b0, rqs_q, 6'h00};
    end

    // error queue pointers; a push into a full queue overwrites the newest entry
    // with the overflow code, so a queue filled exactly to depth keeps every error
    // a second error read while one is in flight must not move the read pointer
    assign err_pop = i_REG_RD && (i_REG_SEL == ISR_SEL_ERRQ) && (count_q != '0)
                   && (err_state_q == ISR_ERR_IDLE);
    always_comb
    begin
        mem_we = 1'b0;
        push_adv = 1'b0;
        mem_waddr = wr_ptr_q;
        mem_wdata = i_ERR_CODE;
        if (i_ERR_PUSH && (err_pop || (count_q < 6'(ISR_ERRQ_DEPTH))))
        begin
            // free slot, or one freed by a pop in the same cycle
            mem_we = 1'b1;
            push_adv = 1'b1;
        end
        else if (i_ERR_PUSH)
        begin
            // full: newest entry gives way; pointers and count stay put
            mem_we = 1'b1;
            mem_waddr = (wr_ptr_q == '0) ? 5'(ISR_ERRQ_DEPTH - 1) : wr_ptr_q - 5'd1;
            mem_wdata = ISR_ERR_OVERFLOW;
        end
    end

    // occupancy; a full queue drops further errors until one is read
    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else if (i_CE)
        begin
            if (push_adv)
                wr_ptr_q <= (wr_ptr_q == 5'(ISR_ERRQ_DEPTH - 1)) ? '0 : wr_ptr_q + 5'd1;
            if (err_pop)
                rd_ptr_q <= (rd_ptr_q == 5'(ISR_ERRQ_DEPTH - 1)) ? '0 : rd_ptr_q + 5'd1;
            count_q <= count_q + 6'(push_adv) - 6'(err_pop);
        end
    end

    isr_errq_mem u_errq_mem
    (
        .i_clk(I_MCLK),
        .i_ce(i_CE),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(rd_ptr_q),
        .o_rdata(mem_rdata)
    );

    // read sequencing: error reads wait one cycle for the memory
    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            err_state_q <= ISR_ERR_IDLE;
            err_empty_q <= 1'b0;
        end
        else if (i_CE)
        begin
            unique case (err_state_q)
                ISR_ERR_IDLE:
                begin
                    if (i_REG_RD && (i_REG_SEL == ISR_SEL_ERRQ))
                    begin
                        err_state_q <= ISR_ERR_READ;
                        err_empty_q <= (count_q == '0);
                    end
                end
                ISR_ERR_READ:
                    err_state_q <= ISR_ERR_IDLE;
                default:
                    err_state_q <= ISR_ERR_IDLE;
            endcase
        end
    end

    // read data mux for everything except the error queue
    always_comb
    begin
        rd_data_d = 16'h0000;
        if (sel_grp_reg)
        begin
            unique case (i_REG_SEL)
                ISR_SEL_QUES_COND: rd_data_d = cond[i_REG_GRP];
                ISR_SEL_QUES_EVENT: rd_data_d = event_q[i_REG_GRP];
                ISR_SEL_QUES_ENABLE: rd_data_d = enable_q[i_REG_GRP];
                ISR_SEL_QUES_RISE: rd_data_d = rise_q[i_REG_GRP];
                default: rd_data_d = fall_q[i_REG_GRP];
            endcase
        end
        else if (i_REG_SEL == ISR_SEL_SRE)
            rd_data_d = {8'h00, sre_q};
        else if (i_REG_SEL == ISR_SEL_ESE)
            rd_data_d = {8'h00, ese_q};
        else if (i_REG_SEL == ISR_SEL_STB)
            rd_data_d = {8'h00, stb | {1'b0, service_summary, 6'h00}};
    end

    // registered read answer; status query leaves every bit alone
    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            o_REG_RDATA <= ISR_RST_REG16;
            o_REG_VALID <= 1'b0;
        end
        else if (i_CE)
        begin
            o_REG_VALID <= 1'b0;
            if (err_state_q == ISR_ERR_READ)
            begin
                o_REG_RDATA <= err_empty_q ? ISR_ERR_NONE : mem_rdata;
                o_REG_VALID <= 1'b1;
            end
            else if (i_REG_RD && (i_REG_SEL != ISR_SEL_ERRQ))
            begin
                o_REG_RDATA <= rd_data_d;
                o_REG_VALID <= 1'b1;
            end
        end
    end
endmodule // isr_status_top

// [isr_pkg.sv]
// package: offsets, field positions, reset values and sizes for the status reporting block
package isr_pkg;
    // register select codes for the host-side access port
    localparam logic [3:0] ISR_SEL_QUES_COND = 4'h0;
    localparam logic [3:0] ISR_SEL_QUES_EVENT = 4'h1;
    localparam logic [3:0] ISR_SEL_QUES_ENABLE = 4'h2;
    localparam logic [3:0] ISR_SEL_QUES_RISE = 4'h3;
    localparam logic [3:0] ISR_SEL_QUES_FALL = 4'h4;
    // group index: 0 abnormal, 1 abnormal two, 2 normal operation, 3 chassis
    localparam int ISR_GROUPS = 4;
    localparam logic [3:0] ISR_SEL_SRE = 4'h8;
    localparam logic [3:0] ISR_SEL_ESE = 4'h9;
    localparam logic [3:0] ISR_SEL_STB = 4'hA;
    localparam logic [3:0] ISR_SEL_ERRQ = 4'hB;
    // implemented bit masks per group (unused bits read zero, except the rising filter until written after reset)
    localparam logic [15:0] ISR_MASK_QUES = 16'h7FFF;
    localparam logic [15:0] ISR_MASK_QUES2 = 16'h7FD9;
    localparam logic [15:0] ISR_MASK_OPER = 16'h3F3C;
    localparam logic [15:0] ISR_MASK_FRAME = 16'h003F;
    // status byte bit positions
    localparam int ISR_STB_QUES2 = 0;
    localparam int ISR_STB_ERRQ = 2;
    localparam int ISR_STB_QUES = 3;
    localparam int ISR_STB_MAV = 4;
    localparam int ISR_STB_ESB = 5;
    localparam int ISR_STB_MSS = 6;
    localparam int ISR_STB_OPER = 7;
    // reset values
    localparam logic [15:0] ISR_RST_REG16 = 16'h0000;
    localparam logic [15:0] ISR_RST_RISE = 16'hFFFF;
    localparam logic [7:0] ISR_RST_REG8 = 8'h00;
    // error queue
    localparam int ISR_ERRQ_DEPTH = 30;
    localparam int ISR_ERRQ_AW = 5;
    localparam logic [15:0] ISR_ERR_OVERFLOW = 16'hFEA2; // -350 two's complement
    localparam logic [15:0] ISR_ERR_NONE = 16'h0000;
    typedef enum logic [1:0] {
        ISR_ERR_IDLE = 2'b00,
        ISR_ERR_READ = 2'b01
    } isr_errq_state_t;
endpackage

// [isr_errq_mem.sv]
// file: small word memory behind the error queue, registered read data
`timescale 1ns/100ps
module isr_errq_mem
(
    // clock and enable
    input wire logic i_clk,
    input wire logic i_ce,
    // write side
    input wire logic i_we,
    input wire logic [4:0] i_waddr,
    input wire logic [15:0] i_wdata,
    // read side
    input wire logic [4:0] i_raddr,
    output logic [15:0] o_rdata
);
    logic [15:0] mem_q [0:29]; // storage words, no reset needed

    // write port
    always_ff @(posedge i_clk)
    begin
        if (i_ce && i_we)
        begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    // registered read port
    always_ff @(posedge i_clk)
    begin
        if (i_ce)
        begin
            o_rdata <= mem_q[i_raddr];
        end
    end
endmodule // isr_errq_mem

// [isr_status_sva.sv]
// port checker for the status reporting block
`timescale 1ns/100ps
module isr_status_sva
(
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_SYS_RST,
    // watched inputs
    input wire logic i_CE,
    input wire logic i_REG_RD,
    input wire logic [3:0] i_REG_SEL,
    input wire logic i_SPOLL,
    input wire logic i_OUTQ_NONEMPTY,
    // watched outputs
    input wire logic o_REG_VALID,
    input wire logic [15:0] o_REG_RDATA,
    input wire logic o_SRQ,
    input wire logic [7:0] o_STB
);
    // one domain, so clock and reset are named once
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_SYS_RST);
    // plain reads answer on the next edge
    a_read_answer:
        assert property (i_CE && i_REG_RD && i_REG_SEL != 4'hB |=> o_REG_VALID)
        else $error("register read without answer");
    // queue pops go through the memory, one edge later
    a_queue_answer:
        assert property ((i_CE && i_REG_RD && i_REG_SEL == 4'hB) ##1 i_CE |=> o_REG_VALID)
        else $error("queue read without answer");
    a_unused_bit:
        assert property (o_STB[1] == 1'b0)
        else $error("unused status bit set");
    a_outq_bit:
        assert property (i_CE && i_SPOLL |=> o_STB[4] == $past(i_OUTQ_NONEMPTY))
        else $error("message bit wrong in poll byte");
    // the poll returns the latch as it stood before the clear
    a_poll_latch:
        assert property (i_CE && i_SPOLL |=> o_STB[6] == $past(o_SRQ))
        else $error("poll byte does not show request latch");
    a_poll_stands:
        assert property (!(i_CE && i_SPOLL) |=> $stable(o_STB))
        else $error("poll byte changed without a poll");
    a_data_stands:
        assert property (!o_REG_VALID |-> $stable(o_REG_RDATA))
        else $error("read data changed without an answer");
    // the latch only drops after a serial poll
    a_srq_holds:
        assert property ($fell(o_SRQ) |-> $past(i_CE) && $past(i_SPOLL))
        else $error("request line dropped without a poll");
endmodule // isr_status_sva

bind isr_status_top isr_status_sva isr_status_sva_i
(
    .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .i_CE(i_CE), .i_REG_RD(i_REG_RD),
    .i_REG_SEL(i_REG_SEL), .i_SPOLL(i_SPOLL), .i_OUTQ_NONEMPTY(i_OUTQ_NONEMPTY),
    .o_REG_VALID(o_REG_VALID), .o_REG_RDATA(o_REG_RDATA), .o_SRQ(o_SRQ), .o_STB(o_STB)
);

// [isr_host_poller.sv]
// host model: answers a service request with one serial poll
`timescale 1ns/100ps
module isr_host_poller
(
    // clock and bench control
    input wire logic i_clk,
    input wire logic i_arm,
    input wire logic [3:0] i_wait,
    // device side
    input wire logic i_srq,
    input wire logic [7:0] i_stb,
    output logic o_spoll,
    // poll result
    output logic [7:0] o_byte,
    output logic o_done
);
    // one poll per arming; the wait models a slow controller
    initial
    begin
        {o_spoll, o_byte, o_done} = '0;
        forever
        begin
            @(posedge i_arm);
            while (i_srq !== 1'b1) @(posedge i_clk);
            repeat (i_wait + 1) @(posedge i_clk);
            #1 o_spoll = 1'b1;
            // strobe spans exactly one sampling edge, byte is ready after it
            @(posedge i_clk);
            #1 {o_spoll, o_byte, o_done} = {1'b0, i_stb, 1'b1};
            @(posedge i_clk);
            #1 o_done = 1'b0;
        end
    end
endmodule // isr_host_poller

// [tb_isr_status_top.sv]
// self-checking bench for the status reporting block
`timescale 1ns/100ps
module tb_isr_status_top;
    // clock, reset and live inputs
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [15:0] ques = 16'h0000;
    logic [15:0] ques2 = 16'h0000;
    logic [15:0] oper = 16'h0000;
    logic [8:0] frame = 9'h000;
    logic [7:0] std_ev = 8'h00;
    logic outq = 1'b0;
    // error producer and register port
    logic push = 1'b0;
    logic [15:0] code = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] grp = 2'h0;
    logic [3:0] sel = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic valid;
    // poll line and host model handshake
    logic spoll;
    logic srq;
    logic [7:0] stb;
    logic arm = 1'b0;
    logic [3:0] delay = 4'h0;
    logic [7:0] poll_byte;
    logic poll_done;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] got;
    // all-ones inputs read back as these masks; one test bit per group except group 0
    logic [15:0] mask [4] = '{16'h7FFF, 16'h7FD9, 16'h3F3C, 16'h003F};
    logic [15:0] tbit [4] = '{16'h0000, 16'h0008, 16'h0100, 16'h0020};
    logic [7:0] sbit [4] = '{8'h00, 8'h01, 8'h80, 8'h08};

    isr_status_top isr_status_top_i
    (
        .I_MCLK(clk), .I_SYS_RST(rst), .i_CE(ce), .i_QUES_COND(ques), .i_QUES2_COND(ques2),
        .i_OPER_COND(oper), .i_FRAME_COND(frame), .i_STD_EVENT(std_ev),
        .i_OUTQ_NONEMPTY(outq), .i_ERR_PUSH(push), .i_ERR_CODE(code), .i_REG_WR(wr),
        .i_REG_RD(rd), .i_REG_GRP(grp), .i_REG_SEL(sel), .i_REG_WDATA(wdata),
        .o_REG_RDATA(rdata), .o_REG_VALID(valid), .i_SPOLL(spoll), .o_SRQ(srq), .o_STB(stb)
    );
    isr_host_poller isr_host_poller_i
    (
        .i_clk(clk), .i_arm(arm), .i_wait(delay), .i_srq(srq), .i_stb(stb),
        .o_spoll(spoll), .o_byte(poll_byte), .o_done(poll_done)
    );

    // 250 MHz clock
    initial
    begin
        forever #2 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // the whole run takes under a thousand cycles, so this only cuts a hang
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            wrap_up();
        end
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] act);
        total_checks++;
        if (act !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, act);
        end
    endtask

    task automatic reg_wr(input logic [1:0] g, input logic [3:0] s, input logic [15:0] d);
        @(posedge clk);
        #1 {wr, grp, sel, wdata} = {1'b1, g, s, d};
        @(posedge clk);
        #1 wr = 1'b0;
    endtask

    // read, then wait a bounded time for the answer
    task automatic rd_chk(input string name, input logic [1:0] g, input logic [3:0] s,
        input logic [15:0] exp);
        @(posedge clk);
        #1 {rd, grp, sel} = {1'b1, g, s};
        @(posedge clk);
        #1 rd = 1'b0;
        for (int i = 0; i < 4 && valid !== 1'b1; i++)
            @(posedge clk) #1;
        got = rdata;
        check("read answer", 16'h0001, {15'h0000, valid});
        check(name, exp, got);
    endtask

    task automatic err_push(input logic [15:0] c);
        @(posedge clk);
        #1 {push, code} = {1'b1, c};
        @(posedge clk);
        #1 push = 1'b0;
    endtask

    // slack after a change covers any input synchroniser
    task automatic set_cond(input int g, input logic [15:0] v);
        @(posedge clk);
        #1;
        case (g)
            0: ques = v;
            1: ques2 = v;
            2: oper = v;
            default: frame = v[8:0];
        endcase
        repeat (3) @(posedge clk);
    endtask

    task automatic poll(input logic [3:0] w, input logic [7:0] exp);
        @(posedge clk);
        #1 {arm, delay} = {1'b1, w};
        wait (poll_done === 1'b1);
        check("poll byte", {8'h00, exp}, {8'h00, poll_byte});
        @(posedge clk);
        #1 arm = 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
    endtask

    initial
    begin
        do_reset();
        rd_chk("rise reset", 0, 4'h3, 16'hFFFF);
        rd_chk("fall reset", 0, 4'h4, 16'h0000);
        rd_chk("enable reset", 0, 4'h2, 16'h0000);
        $display("test reset values done");
        for (int g = 0; g < 4; g++)
            set_cond(g, 16'hFFFF);
        for (int g = 0; g < 4; g++)
        begin
            rd_chk("condition", g[1:0], 4'h0, mask[g]);
            rd_chk("event", g[1:0], 4'h1, mask[g]);
            rd_chk("event cleared", g[1:0], 4'h1, 16'h0000);
        end
        $display("test bit maps done");
        // falling edge only on bit 0 of the abnormal group
        reg_wr(0, 4'h2, 16'h0001);
        rd_chk("enable", 0, 4'h2, 16'h0001);
        reg_wr(0, 4'h3, 16'h0000);
        reg_wr(0, 4'h4, 16'h0001);
        reg_wr(0, 4'h8, 16'h0008);
        rd_chk("idle status", 0, 4'hA, 16'h0000);
        for (int g = 0; g < 4; g++)
            set_cond(g, 16'h0000);
        rd_chk("status fall", 0, 4'hA, 16'h0048);
        check("request line", 16'h0001, {15'h0000, srq});
        rd_chk("abn events", 0, 4'h1, 16'h0001);
        rd_chk("abn2 events", 1, 4'h1, 16'h0000);
        poll(4'h0, 8'h40);
        check("request cleared", 16'h0000, {15'h0000, srq});
        $display("test filters and request done");
        reg_wr(0, 4'h8, 16'h0000);
        for (int g = 1; g < 4; g++)
        begin
            reg_wr(g[1:0], 4'h2, tbit[g]);
            set_cond(g, tbit[g]);
            rd_chk("group summary", 0, 4'hA, {8'h00, sbit[g]});
            rd_chk("group event", g[1:0], 4'h1, tbit[g]);
            set_cond(g, 16'h0000);
        end
        $display("test group summaries done");
        // thirty errors fit; one pop after the 30th, then the 32nd overflows
        // and replaces the newest entry (31) with the overflow code
        for (int i = 1; i <= 32; i++)
        begin
            err_push(16'(i));
            if (i == 30)
                rd_chk("queue first", 0, 4'hB, 16'h0001);
        end
        rd_chk("status queue", 0, 4'hA, 16'h0004);
        for (int i = 2; i <= 31; i++)
            rd_chk("queue entry", 0, 4'hB, (i == 31) ? 16'hFEA2 : 16'(i));
        rd_chk("queue empty", 0, 4'hB, 16'h0000);
        rd_chk("status no queue", 0, 4'hA, 16'h0000);
        $display("test error queue done");
        @(posedge clk);
        #1 {outq, std_ev} = {1'b1, 8'h20};
        rd_chk("status outq", 0, 4'hA, 16'h0010);
        reg_wr(0, 4'h9, 16'h0020);
        reg_wr(0, 4'h8, 16'h0010);
        rd_chk("status std", 0, 4'hA, 16'h0070);
        rd_chk("status again", 0, 4'hA, 16'h0070);
        poll(4'h5, 8'h70);
        check("request kept", 16'h0001, {15'h0000, srq});
        @(posedge clk);
        #1 outq = 1'b0;
        poll(4'h0, 8'h60);
        check("request dropped", 16'h0000, {15'h0000, srq});
        $display("test queues and polls done");
        do_reset();
        rd_chk("enable after reset", 2, 4'h2, 16'h0000);
        $display("test second reset done");
        wrap_up();
    end
endmodule // tb_isr_status_top
